//--- src/art_pkg.sv
package art_pkg;

    // Counter geometry
    localparam int ART_BYTE_W = 8;
    localparam int ART_CNT_W = 16;
    localparam logic [15:0] ART_CNT_MAX = 16'hffff;
    localparam logic [7:0] ART_BYTE_MAX = 8'hff;
    localparam logic [15:0] ART_CNT_RESET = 16'h0000;

    // Clock dividers
    localparam int ART_SYS_DIV = 12;
    localparam logic [3:0] ART_SYS_DIV_LAST = 4'(ART_SYS_DIV - 1);
    localparam int ART_RTC_DIV = 8;
    localparam logic [2:0] ART_RTC_DIV_LAST = 3'(ART_RTC_DIV - 1);

    // Bit positions in the control view byte
    localparam int ART_CTL_HI_FLAG = 7;
    localparam int ART_CTL_LO_FLAG = 6;
    localparam int ART_CTL_LO_IRQ_EN = 5;
    localparam int ART_CTL_SPLIT = 3;

    // Count clock sources
    typedef enum logic [1:0] {
        ART_CLK_SYS,
        ART_CLK_SYS_DIV12,
        ART_CLK_RTC_DIV8,
        ART_CLK_CMP
    } art_clk_sel_e;

    // Software write port
    typedef struct packed {
        logic wr_low;
        logic wr_high;
        logic [7:0] data;
    } art_wr_s;

    // Whole state of the timer
    typedef struct packed {
        logic [3:0] div12_cnt;
        logic [1:0] rtc_sync;
        logic rtc_prev;
        logic [2:0] rtc_div;
        logic [1:0] cmp_sync;
        logic cmp_prev;
        logic [15:0] cnt;
        logic [15:0] cap_val;
        logic hi_flag;
        logic lo_flag;
        logic irq;
        logic [7:0] ctl_view;
    } art_state_s;

endpackage

//--- src/art_timer.sv
`timescale 1ns/1ns
// Function
// - Count is 16 bits in two bytes
// - Split bit selects 16-bit or dual 8-bit
// - Capture latches count on source edge
// - Count clock from four selectable sources
// - Slow sources synchronised to system clock
// - 16-bit rollover loads reload pair
// - 16-bit rollover sets high overflow flag
// - Timer interrupt enable requests on overflow
// - Low byte rollover requests when both low byte and timer interrupt enables are set
module art_timer
    import art_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic run_enable,
    input wire logic split_mode_select,
    input wire art_clk_sel_e clock_select,
    input wire logic capture_enable,
    input wire logic capture_from_comparator,
    input wire logic timer_irq_enable,
    input wire logic low_byte_irq_enable,
    input wire logic high_flag_clear,
    input wire logic low_flag_clear,
    // Software writes and reload value
    input wire art_wr_s counter_write,
    input wire logic [7:0] reload_low_byte,
    input wire logic [7:0] reload_high_byte,
    // Slow sources
    input wire logic rtc_clock_in,
    input wire logic comparator_in,
    // Status
    output logic [7:0] counter_low_byte,
    output logic [7:0] counter_high_byte,
    output logic [15:0] capture_value,
    output logic high_overflow_flag,
    output logic low_overflow_flag,
    output logic [7:0] timer_control_register,
    output logic irq
);

    art_state_s st_r;
    art_state_s st_nxt;
    logic div12_pulse;
    logic rtc8_pulse;
    logic cmp_pulse;
    logic tick;
    logic lo_roll;
    logic hi_roll;
    logic cap_event;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Dividers and synchronisers
        div12_pulse = (st_r.div12_cnt == ART_SYS_DIV_LAST);
        st_nxt.div12_cnt = div12_pulse ? 4'h0 : st_r.div12_cnt + 4'h1;
        st_nxt.rtc_sync = {st_r.rtc_sync[0], rtc_clock_in};
        st_nxt.rtc_prev = st_r.rtc_sync[1];
        st_nxt.cmp_sync = {st_r.cmp_sync[0], comparator_in};
        st_nxt.cmp_prev = st_r.cmp_sync[1];
        rtc8_pulse = 1'b0;
        if (st_r.rtc_sync[1] && !st_r.rtc_prev) begin
            st_nxt.rtc_div = st_r.rtc_div + 3'h1;
            rtc8_pulse = (st_r.rtc_div == ART_RTC_DIV_LAST);
        end
        cmp_pulse = st_r.cmp_sync[1] && !st_r.cmp_prev;
        // Source selection
        case (clock_select)
            ART_CLK_SYS: tick = 1'b1;
            ART_CLK_SYS_DIV12: tick = div12_pulse;
            ART_CLK_RTC_DIV8: tick = rtc8_pulse;
            ART_CLK_CMP: tick = cmp_pulse;
            default: tick = 1'b0;
        endcase
        tick = tick && run_enable;
        // Counting
        lo_roll = tick && (st_r.cnt[7:0] == ART_BYTE_MAX);
        hi_roll = tick && (split_mode_select ? (st_r.cnt[15:8] == ART_BYTE_MAX)
                                             : (st_r.cnt == ART_CNT_MAX));
        if (tick) begin
            if (split_mode_select) begin
                st_nxt.cnt[7:0] = lo_roll ? reload_low_byte : st_r.cnt[7:0] + 8'h01;
                st_nxt.cnt[15:8] = hi_roll ? reload_high_byte
                                           : st_r.cnt[15:8] + 8'h01;
            end else if (hi_roll) begin
                st_nxt.cnt = {reload_high_byte, reload_low_byte};
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end
        // Software writes win over the count
        if (counter_write.wr_low) begin
            st_nxt.cnt[7:0] = counter_write.data;
        end
        if (counter_write.wr_high) begin
            st_nxt.cnt[15:8] = counter_write.data;
        end
        // Capture
        cap_event = capture_enable && (capture_from_comparator ? cmp_pulse : rtc8_pulse);
        if (cap_event) begin
            st_nxt.cap_val = st_r.cnt;
        end
        // Flags, set wins over clear
        st_nxt.hi_flag = hi_roll || cap_event || (st_r.hi_flag && !high_flag_clear);
        st_nxt.lo_flag = lo_roll || (st_r.lo_flag && !low_flag_clear);
        st_nxt.irq = timer_irq_enable
                     && (st_r.hi_flag || (low_byte_irq_enable && st_r.lo_flag));
        st_nxt.ctl_view = 8'h00;
        st_nxt.ctl_view[ART_CTL_HI_FLAG] = st_nxt.hi_flag;
        st_nxt.ctl_view[ART_CTL_LO_FLAG] = st_nxt.lo_flag;
        st_nxt.ctl_view[ART_CTL_LO_IRQ_EN] = low_byte_irq_enable;
        st_nxt.ctl_view[ART_CTL_SPLIT] = split_mode_select;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign counter_low_byte = st_r.cnt[7:0];
    assign counter_high_byte = st_r.cnt[15:8];
    assign capture_value = st_r.cap_val;
    assign high_overflow_flag = st_r.hi_flag;
    assign low_overflow_flag = st_r.lo_flag;
    assign timer_control_register = st_r.ctl_view;
    assign irq = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking art_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic no_wr;
    assign no_wr = !counter_write.wr_low && !counter_write.wr_high;

    a_count_halves: assert property (
        counter_write.wr_high |=> counter_high_byte == $past(counter_write.data))
        else $error("High byte write not taken");
    a_split_reload: assert property (
        split_mode_select && lo_roll && no_wr
        |=> counter_low_byte == $past(reload_low_byte))
        else $error("Split low byte did not reload");
    a_capture_latch: assert property (
        cap_event |=> capture_value == $past(st_r.cnt) && high_overflow_flag)
        else $error("Capture did not latch count");
    a_div12_gap: assert property (
        div12_pulse |=> !div12_pulse [*8])
        else $error("Divide by twelve pulse too close");
    a_cmp_sync: assert property (
        cmp_pulse && $past(resetn, 3)
        |-> $past(comparator_in, 2) && !$past(comparator_in, 3))
        else $error("Comparator edge not synchronised");
    a_wide_reload: assert property (
        !split_mode_select && hi_roll && no_wr
        |=> {counter_high_byte, counter_low_byte}
            == {$past(reload_high_byte), $past(reload_low_byte)})
        else $error("Wide reload missing");
    a_high_flag_set: assert property (
        hi_roll |=> high_overflow_flag)
        else $error("Overflow flag not set");
    a_irq_overflow: assert property (
        high_overflow_flag && timer_irq_enable |=> irq)
        else $error("Overflow interrupt missing");
    a_low_irq: assert property (
        low_overflow_flag && timer_irq_enable && low_byte_irq_enable |=> irq)
        else $error("Low byte interrupt missing");
    a_split_high: assert property (
        split_mode_select && hi_roll && no_wr
        |=> counter_high_byte == $past(reload_high_byte))
        else $error("Split high byte did not reload");
    a_count_step: assert property (
        tick && !hi_roll && !split_mode_select && no_wr
        |=> {counter_high_byte, counter_low_byte} == $past(st_r.cnt) + 16'h0001)
        else $error("Count step wrong");
    a_idle_hold: assert property (
        !tick && no_wr |=> {counter_high_byte, counter_low_byte} == $past(st_r.cnt))
        else $error("Count moved without tick");
    a_low_flag_set: assert property (
        lo_roll |=> low_overflow_flag)
        else $error("Low overflow flag not set");
    a_high_clear: assert property (
        high_flag_clear && !hi_roll && !cap_event |=> !high_overflow_flag)
        else $error("High overflow flag not cleared");
    a_run_gate: assert property (
        !run_enable && no_wr |=> {counter_high_byte, counter_low_byte} == $past(st_r.cnt))
        else $error("Count moved while stopped");
    a_split_view: assert property (
        1'b1 |=> timer_control_register[ART_CTL_SPLIT] == $past(split_mode_select)
            && timer_control_register[ART_CTL_LO_IRQ_EN] == $past(low_byte_irq_enable))
        else $error("Control view bits wrong");
    a_irq_quiet: assert property (
        !timer_irq_enable |=> !irq)
        else $error("Interrupt while disabled");
    a_capture_hold: assert property (
        !cap_event |=> capture_value == $past(capture_value))
        else $error("Capture value moved without event");
    a_div12_period: assert property (
        div12_pulse |-> ##12 div12_pulse)
        else $error("Divide by twelve period wrong");
    a_wide_low_roll: assert property (
        !split_mode_select && lo_roll && !hi_roll && no_wr
        |=> counter_low_byte == 8'h00 && counter_high_byte == $past(st_r.cnt[15:8]) + 8'h01)
        else $error("Low byte carry wrong");

    c_wide_roll: cover property (!split_mode_select && hi_roll);
    c_split_roll: cover property (split_mode_select && lo_roll);
    c_capture: cover property (cap_event);
    c_irq: cover property (irq);
    c_set_wins: cover property (hi_roll && high_flag_clear);

endmodule

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
    import art_pkg::*;
    logic clock, resetn, run_enable, split_mode_select, capture_enable, capture_from_comparator;
    logic timer_irq_enable, low_byte_irq_enable, high_flag_clear, low_flag_clear;
    logic rtc_clock_in, comparator_in, high_overflow_flag, low_overflow_flag, irq;
    art_clk_sel_e clock_select;
    art_wr_s counter_write;
    logic [7:0] reload_low_byte, reload_high_byte, counter_low_byte, counter_high_byte;
    logic [7:0] timer_control_register;
    logic [15:0] capture_value, cnt;
    int miscompares = 0;
    int samples_checked = 0;
    assign cnt = {counter_high_byte, counter_low_byte};
    art_timer i_dut (.clock(clock), .resetn(resetn), .run_enable(run_enable),
        .split_mode_select(split_mode_select), .clock_select(clock_select),
        .capture_enable(capture_enable), .capture_from_comparator(capture_from_comparator),
        .timer_irq_enable(timer_irq_enable), .low_byte_irq_enable(low_byte_irq_enable),
        .high_flag_clear(high_flag_clear), .low_flag_clear(low_flag_clear),
        .counter_write(counter_write), .reload_low_byte(reload_low_byte),
        .reload_high_byte(reload_high_byte), .rtc_clock_in(rtc_clock_in),
        .comparator_in(comparator_in), .counter_low_byte(counter_low_byte),
        .counter_high_byte(counter_high_byte), .capture_value(capture_value),
        .high_overflow_flag(high_overflow_flag), .low_overflow_flag(low_overflow_flag),
        .timer_control_register(timer_control_register), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [15:0] v);
        counter_write = {1'b1, 1'b0, v[7:0]};
        cyc(1);
        counter_write = {1'b0, 1'b1, v[15:8]};
        cyc(1);
        counter_write = '0;
        cyc(1);
    endtask
    task automatic tick_once();
        run_enable = 1'b1;
        cyc(1);
        run_enable = 1'b0;
    endtask
    task automatic clear_flags();
        high_flag_clear = 1'b1;
        low_flag_clear = 1'b1;
        cyc(1);
        high_flag_clear = 1'b0;
        low_flag_clear = 1'b0;
        cyc(2);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_roll16();
        wr(16'hffff);
        timer_irq_enable = 1'b1;
        tick_once();
        check(cnt, 16'h1234);
        check(16'(high_overflow_flag), 16'h0001);
        check(16'(timer_control_register[ART_CTL_HI_FLAG]), 16'h0001);
        cyc(1);
        check(16'(irq), 16'h0001);
        clear_flags();
        check(16'(irq), 16'h0000);
        $display("Test roll16 done");
    endtask
    task automatic t_lowirq();
        wr(16'h00ff);
        low_byte_irq_enable = 1'b1;
        tick_once();
        check(cnt, 16'h0100);
        check({14'h0000, high_overflow_flag, low_overflow_flag}, 16'h0001);
        check(16'(timer_control_register), 16'h0060);
        cyc(1);
        check(16'(irq), 16'h0001);
        timer_irq_enable = 1'b0;
        cyc(2);
        check(16'(irq), 16'h0000);
        clear_flags();
        $display("Test lowirq done");
    endtask
    task automatic t_split();
        split_mode_select = 1'b1;
        wr(16'h7fff);
        tick_once();
        check(cnt, 16'h8034);
        check(16'(timer_control_register[ART_CTL_SPLIT]), 16'h0001);
        wr(16'hff10);
        tick_once();
        check(cnt, 16'h1211);
        split_mode_select = 1'b0;
        clear_flags();
        $display("Test split done");
    endtask
    task automatic t_sources();
        wr(16'h0000);
        clock_select = ART_CLK_SYS_DIV12;
        run_enable = 1'b1;
        cyc(36);
        run_enable = 1'b0;
        cyc(2);
        check(cnt, 16'h0003);
        wr(16'h0000);
        clock_select = ART_CLK_CMP;
        run_enable = 1'b1;
        comparator_in = 1'b1;
        cyc(2);
        check(cnt, 16'h0000);
        cyc(8);
        check(cnt, 16'h0001);
        clock_select = ART_CLK_RTC_DIV8;
        for (int k = 0; k < 16; k++) begin
            rtc_clock_in = 1'b1;
            cyc(3);
            rtc_clock_in = 1'b0;
            cyc(3);
        end
        cyc(4);
        check(cnt, 16'h0003);
        run_enable = 1'b0;
        comparator_in = 1'b0;
        clock_select = ART_CLK_SYS;
        $display("Test sources done");
    endtask
    task automatic t_capture();
        wr(16'h0abc);
        cyc(4);
        capture_enable = 1'b1;
        capture_from_comparator = 1'b1;
        comparator_in = 1'b1;
        cyc(8);
        check(capture_value, 16'h0abc);
        check(cnt, 16'h0abc);
        check(16'(high_overflow_flag), 16'h0001);
        capture_enable = 1'b0;
        comparator_in = 1'b0;
        $display("Test capture done");
    endtask
    task automatic t_rtc_capture();
        wr(16'h0555);
        capture_enable = 1'b1;
        capture_from_comparator = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (k == 7) begin
                check(capture_value, 16'h0abc);
            end
            rtc_clock_in = 1'b1;
            cyc(3);
            rtc_clock_in = 1'b0;
            cyc(3);
        end
        cyc(4);
        check(capture_value, 16'h0555);
        capture_enable = 1'b0;
        clear_flags();
        $display("Test rtc capture done");
    endtask
    task automatic t_setwins();
        wr(16'hffff);
        high_flag_clear = 1'b1;
        low_flag_clear = 1'b1;
        tick_once();
        high_flag_clear = 1'b0;
        low_flag_clear = 1'b0;
        check({14'h0000, high_overflow_flag, low_overflow_flag}, 16'h0003);
        cyc(1);
        check({14'h0000, high_overflow_flag, low_overflow_flag}, 16'h0003);
        clear_flags();
        check({14'h0000, high_overflow_flag, low_overflow_flag}, 16'h0000);
        $display("Test set wins done");
    endtask
    task automatic t_reset_mid();
        wr(16'h4321);
        resetn = 1'b0;
        cyc(2);
        check(cnt, 16'h0000);
        check(capture_value, 16'h0000);
        check({timer_control_register, 7'h00, irq}, 16'h0000);
        resetn = 1'b1;
        cyc(1);
        check(16'(timer_control_register), 16'h0020);
        tick_once();
        check(cnt, 16'h0001);
        $display("Test reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {run_enable, split_mode_select, capture_enable, capture_from_comparator} = '0;
        {timer_irq_enable, low_byte_irq_enable, high_flag_clear, low_flag_clear} = '0;
        {rtc_clock_in, comparator_in} = '0;
        clock_select = ART_CLK_SYS;
        counter_write = '0;
        reload_low_byte = 8'h34;
        reload_high_byte = 8'h12;
        cyc(5);
        check(cnt, 16'h0000);
        check({timer_control_register, 7'h00, irq}, 16'h0000);
        resetn = 1'b1;
        cyc(1);
        t_roll16();
        t_lowirq();
        t_split();
        t_sources();
        t_capture();
        t_rtc_capture();
        t_setwins();
        t_reset_mid();
        complete_run();
    end
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule
